//--- verif/rss_dbg_host.sv
`timescale 1ns/1ps

// Debug host at the far side of the debug port; it only issues byte commands.
module rss_dbg_host (
	input  wire logic       clk,
	output logic [15:0]     addr,
	output logic            wr,
	output logic            rd,
	output logic [7:0]      wdata,
	input  wire logic [7:0] rdata
);
	initial begin
		addr = 16'hFFFF;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'hFF;
	end

	// Released lines show the inverse of the last value so nothing stale looks valid.
	task automatic write_byte(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask

	task automatic read_byte(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask
endmodule

//--- verif/rss_reset_status_tb_top.sv
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_reset_status_tb_top;
	logic               mclk = 1'b0;
	logic               rst_n = 1'b0;
	logic [15:0]        cpu_addr = 16'h0000;
	logic               cpu_wr = 1'b0;
	logic               cpu_rd = 1'b0;
	logic [7:0]         cpu_wdata = 8'h00;
	logic [7:0]         src = 8'h00;
	logic               wdog_en = 1'b1;
	logic               stop_en = 1'b0;
	logic               lvs_en = 1'b1;
	logic               lvr_en = 1'b1;
	rss_pkg::rss_mode_t mode = rss_pkg::RSS_MODE_RUN;
	logic [15:0]        dbg_addr;
	logic               dbg_wr;
	logic               dbg_rd;
	logic [7:0]         dbg_wdata;
	logic [7:0]         cpu_rdata;
	logic [7:0]         dbg_rdata;
	logic               wd_restart;
	logic               wake_flag;
	logic               mcu_rst;
	logic               seen_rst = 1'b0;
	logic               seen_wake = 1'b0;
	logic               seen_wdr = 1'b0;
	int                 mismatches = 0;
	int                 samples_checked = 0;

	always #20 mclk = ~mclk;

	// Source pulses: 0 pin, 1 watchdog, 2 opcode, 3 stop, 4 background, 5 address, 6 wake-up, 7 trip.
	rss_reset_status #(.HOLD_CYC(2)) u_rss_reset_status (
		.MCLK_I(mclk), .RST_N_I(rst_n), .CPU_ADDR_I(cpu_addr), .CPU_WR_I(cpu_wr), .CPU_RD_I(cpu_rd),
		.CPU_WDATA_I(cpu_wdata), .CPU_RDATA_O(cpu_rdata), .DBG_ADDR_I(dbg_addr), .DBG_WR_I(dbg_wr),
		.DBG_RD_I(dbg_rd), .DBG_WDATA_I(dbg_wdata), .DBG_RDATA_O(dbg_rdata), .RESET_PIN_N_I(~src[0]),
		.SUPPLY_BELOW_TRIP_I(src[7]), .LOW_VOLTAGE_RESET_ENABLE_I(lvr_en), .LOW_VOLTAGE_STOP_DETECT_ENABLE_I(lvs_en),
		.WATCHDOG_TIMEOUT_I(src[1]), .WATCHDOG_ENABLE_I(wdog_en), .UNIMPL_OPCODE_I(src[2]),
		.STOP_EXEC_I(src[3]), .BACKGROUND_EXEC_I(src[4]), .STOP_MODE_ENABLE_I(stop_en),
		.BACKGROUND_MODE_ENABLE_I(stop_en), .ILLEGAL_ADDRESS_I(src[5]), .WAKEUP_RESET_I(src[6]),
		.POWER_MODE_I(mode), .WATCHDOG_RESTART_O(wd_restart), .WAKEUP_SOURCE_FLAG_O(wake_flag),
		.MCU_RESET_O(mcu_rst));

	rss_dbg_host u_rss_dbg_host (.clk(mclk), .addr(dbg_addr), .wr(dbg_wr), .rd(dbg_rd),
		.wdata(dbg_wdata), .rdata(dbg_rdata));

	// Pulsed outputs (reset hold, watchdog restart, wake-up flag) are latched here so a scenario can judge them afterwards.
	always @(posedge mclk) begin
		if (mcu_rst) seen_rst <= 1'b1;
		if (wake_flag) seen_wake <= 1'b1;
		if (wd_restart) seen_wdr <= 1'b1;
	end

	task automatic check(input rss_pkg::rss_byte_t seen, input rss_pkg::rss_byte_t exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cpu_read(input logic [15:0] a, output rss_pkg::rss_byte_t d);
		@(posedge mclk);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge mclk);
		cpu_rd <= 1'b0;
		#1;
		d = cpu_rdata;
	endtask

	task automatic cpu_write(input logic [15:0] a, input rss_pkg::rss_byte_t v);
		@(posedge mclk);
		cpu_addr <= a;
		cpu_wdata <= v;
		cpu_wr <= 1'b1;
		@(posedge mclk);
		cpu_wr <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	// Pulses the given sources for one cycle, waits out the hold and reads the flags back.
	task automatic cause(input logic [7:0] v, input rss_pkg::rss_byte_t exp, input logic r);
		rss_pkg::rss_byte_t d;
		seen_rst = 1'b0;
		@(posedge mclk);
		src <= v;
		@(posedge mclk);
		src <= 8'h00;
		repeat (12) @(posedge mclk);
		cpu_read(`RSS_ADDR_RESET_CAUSE, d);
		check(d, exp);
		check({7'h00, seen_rst}, {7'h00, r});
	endtask

	task automatic test_power_on();
		rss_pkg::rss_byte_t d;
		cpu_read(`RSS_ADDR_RESET_CAUSE, d);
		check(d, `RSS_FLAGS_POR);
		cpu_read(`RSS_ADDR_DEBUG_FORCE, d);
		check(d, `RSS_ZERO_BYTE);
	endtask

	task automatic test_cpu_writes();
		rss_pkg::rss_byte_t d;
		cpu_write(`RSS_ADDR_RESET_CAUSE, 8'hFF);
		check({7'h00, seen_wdr}, 8'h01);
		cpu_read(`RSS_ADDR_RESET_CAUSE, d);
		check(d, `RSS_FLAGS_POR);
		seen_rst = 1'b0;
		cpu_write(`RSS_ADDR_DEBUG_FORCE, 8'h01);
		check({7'h00, seen_rst}, 8'h00);
	endtask

	task automatic test_debug_force();
		rss_pkg::rss_byte_t d;
		seen_rst = 1'b0;
		u_rss_dbg_host.write_byte(`RSS_ADDR_DEBUG_FORCE, 8'h01);
		repeat (12) @(posedge mclk);
		check({7'h00, seen_rst}, 8'h01);
		cpu_read(`RSS_ADDR_RESET_CAUSE, d);
		check(d, 8'h00);
		u_rss_dbg_host.read_byte(`RSS_ADDR_DEBUG_FORCE, d);
		check(d, `RSS_ZERO_BYTE);
		u_rss_dbg_host.read_byte(`RSS_ADDR_RESET_CAUSE, d);
		check(d, 8'h00);
	endtask

	task automatic test_sources();
		cause(8'h01, 8'h40, 1'b1);
		cause(8'h02, 8'h20, 1'b1);
		cause(8'h04, 8'h10, 1'b1);
		cause(8'h08, 8'h10, 1'b1);
		cause(8'h10, 8'h10, 1'b1);
		cause(8'h20, 8'h08, 1'b1);
		cause(8'h40, 8'h04, 1'b1);
		cause(8'h23, 8'h68, 1'b1);
	endtask

	task automatic test_blocked();
		@(posedge mclk);
		wdog_en <= 1'b0;
		stop_en <= 1'b1;
		lvs_en <= 1'b0;
		cause(8'h02, 8'h68, 1'b0);
		cause(8'h18, 8'h68, 1'b0);
		cause(8'h80, 8'h68, 1'b0);
		@(posedge mclk);
		lvs_en <= 1'b1;
		lvr_en <= 1'b0;
		cause(8'h80, 8'h68, 1'b0);
		@(posedge mclk);
		lvr_en <= 1'b1;
		cause(8'h80, `RSS_FLAGS_POR, 1'b1);
	endtask

	task automatic test_deep_wake();
		@(posedge mclk);
		mode <= rss_pkg::RSS_MODE_STOP3;
		cause(8'h40, 8'h04, 1'b1);
		seen_wake = 1'b0;
		@(posedge mclk);
		mode <= rss_pkg::RSS_MODE_STOP2;
		cause(8'h40, 8'h00, 1'b1);
		check({7'h00, seen_wake}, 8'h01);
		seen_wake = 1'b0;
		@(posedge mclk);
		mode <= rss_pkg::RSS_MODE_STOP1;
		cause(8'h40, 8'h00, 1'b1);
		check({7'h00, seen_wake}, 8'h01);
	endtask

	// A second power-on reset in mid-run must bring back the power-on flags.
	task automatic test_mid_reset();
		rss_pkg::rss_byte_t d;
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		check({7'h00, mcu_rst}, 8'h01);
		repeat (6) @(posedge mclk);
		cpu_read(`RSS_ADDR_RESET_CAUSE, d);
		check(d, `RSS_FLAGS_POR);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		test_power_on();
		test_cpu_writes();
		test_debug_force();
		test_sources();
		test_blocked();
		test_deep_wake();
		test_mid_reset();
		summarize();
	end
endmodule

//--- verilog/rss_capture.sv
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_capture #(
	parameter int HOLD_CYC = `RSS_RESET_HOLD_CYC
) (
	input  wire logic   clk,
	input  wire logic   rst_n,
	rss_cause_if.cap    cif
);
	localparam int CW = $clog2(HOLD_CYC + 1);

	logic [CW-1:0]      cnt;
	logic               trigger;
	rss_pkg::rss_byte_t next_flags;

	assign trigger = (|cif.cause) | cif.quiet_reset;
	assign cif.in_reset = (cnt != '0);

	always_comb begin
		// A supply-related cause overrides every other source.
		if (cif.cause[`RSS_BIT_POR]) begin
			next_flags = `RSS_FLAGS_POR; // see R4
		end else if (cnt == '0) begin
			next_flags = cif.cause & `RSS_STATUS_MASK; // see R5 see R2 see R16
		end else begin
			next_flags = (cif.flags | cif.cause) & `RSS_STATUS_MASK; // see R5
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= CW'(HOLD_CYC);
		end else if (trigger) begin
			cnt <= CW'(HOLD_CYC); // see R14
		end else if (cnt != '0) begin
			cnt <= cnt - CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cif.flags <= `RSS_FLAGS_POR; // see R4
		end else if (trigger) begin
			cif.flags <= next_flags; // see R1
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	quiet_clears_flags_a: assert property (cif.quiet_reset && cif.cause == '0 && !cif.in_reset |=> cif.flags == '0) // see R2
		else $error("quiet reset left a cause flag set");
	por_flag_value_a: assert property (cif.cause[`RSS_BIT_POR] |=> cif.flags == `RSS_FLAGS_POR) // see R4
		else $error("power-on flags wrong");
	other_flag_value_a: assert property (trigger && !cif.in_reset && !cif.cause[`RSS_BIT_POR]
		|=> cif.flags == ($past(cif.cause) & `RSS_STATUS_MASK)) // see R5
		else $error("cause flags do not match the active sources");
	hold_count_a: assert property (cif.in_reset && !trigger |=> cnt == $past(cnt) - CW'(1)) // see R14
		else $error("reset hold counter did not step down");
endmodule

//--- verilog/rss_cause_if.sv
`timescale 1ns/1ps

interface rss_cause_if;
	rss_pkg::rss_byte_t cause;
	logic               quiet_reset;
	rss_pkg::rss_byte_t flags;
	logic               in_reset;

	modport src (output cause, output quiet_reset, input flags, input in_reset);
	modport cap (input cause, input quiet_reset, output flags, output in_reset);
endinterface

//--- verilog/rss_cfg.svh
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// Bit positions inside the reset cause status byte.
`define RSS_BIT_POR 7
`define RSS_BIT_PIN 6
`define RSS_BIT_WDOG 5
`define RSS_BIT_OPCODE 4
`define RSS_BIT_BADADDR 3
`define RSS_BIT_WAKE 2
`define RSS_BIT_LOWV 1

// Bit position of the force bit inside the debug force reset byte.
`define RSS_BIT_FORCE 0

// Flag values after a power-on or low-voltage reset.
`define RSS_FLAGS_POR 8'h82
// Bits of the status byte that are implemented; bit 0 always reads zero.
`define RSS_STATUS_MASK 8'hFE
`define RSS_ZERO_BYTE 8'h00

// Register addresses on the CPU and debug buses.
`define RSS_ADDR_RESET_CAUSE 16'h1800
`define RSS_ADDR_DEBUG_FORCE 16'h1801

// Internal reset hold time and its cycle count at the bus clock.
`define RSS_CLK_MHZ 25
`define RSS_RESET_HOLD_NS 320
`define RSS_RESET_HOLD_CYC ((`RSS_RESET_HOLD_NS * `RSS_CLK_MHZ + 999) / 1000)

`endif

//--- verilog/rss_pkg.sv
package rss_pkg;

	typedef enum logic [2:0] {
		RSS_MODE_RUN,
		RSS_MODE_WAIT,
		RSS_MODE_STOP4,
		RSS_MODE_STOP3,
		RSS_MODE_STOP2,
		RSS_MODE_STOP1
	} rss_mode_t;

	typedef logic [7:0] rss_byte_t;

endpackage

//--- verilog/rss_reset_status.sv
`timescale 1ns/1ps
`include "rss_cfg.svh"

// Operation
// R1 - Seven read-only flags record the cause of the latest reset and CPU writes never alter them.
// R2 - A reset forced by the debug host leaves every cause flag clear.
// R3 - A CPU write of any value to the status address restarts the watchdog and leaves the flags alone.
// R4 - A power-on or low-voltage reset sets bits 7 and 1 and clears all other flags.
// R5 - Any other reset sets each flag in bits 6 to 2 whose source was active and clears the rest.
// R6 - Bit 6 records a reset caused by the active-low external reset pin.
// R7 - Bit 5 records a watchdog timeout reset, which is blocked while the watchdog enable is 0.
// R8 - Bit 4 records an illegal opcode, including stop with stop mode off and background entry with it off.
// R9 - Bit 3 records an access to an unimplemented memory address.
// R10 - Bit 2 records a wake-up reset in run, wait, stop4 or stop3, while stop2 or stop1 exit flags the wake-up unit.
// R11 - A low-voltage reset happens only with both low-voltage enables set and the supply below the trip level.
// R12 - User program writes to the debug force register are ignored; only debug commands write it.
// R13 - Every read of the debug force register returns zero.
// R14 - A debug write of one to the force bit resets the whole controller.
// R15 - The debug host forces a reset by writing the force register with a serial memory-write command.
// R16 - Bit 0 of the status register is unimplemented and reads zero.
module rss_reset_status #(
	parameter int                 ADDR_W   = 16,
	parameter logic [ADDR_W-1:0] STATUS_AD = `RSS_ADDR_RESET_CAUSE,
	parameter logic [ADDR_W-1:0] FORCE_AD  = `RSS_ADDR_DEBUG_FORCE,
	parameter int                 HOLD_CYC = `RSS_RESET_HOLD_CYC
) (
	input  wire logic              MCLK_I,
	input  wire logic              RST_N_I,
	input  wire logic [ADDR_W-1:0] CPU_ADDR_I,
	input  wire logic              CPU_WR_I,
	input  wire logic              CPU_RD_I,
	input  wire logic [7:0]        CPU_WDATA_I,
	output logic      [7:0]        CPU_RDATA_O,
	input  wire logic [ADDR_W-1:0] DBG_ADDR_I,
	input  wire logic              DBG_WR_I,
	input  wire logic              DBG_RD_I,
	input  wire logic [7:0]        DBG_WDATA_I,
	output logic      [7:0]        DBG_RDATA_O,
	input  wire logic              RESET_PIN_N_I,
	input  wire logic              SUPPLY_BELOW_TRIP_I,
	input  wire logic              LOW_VOLTAGE_RESET_ENABLE_I,
	input  wire logic              LOW_VOLTAGE_STOP_DETECT_ENABLE_I,
	input  wire logic              WATCHDOG_TIMEOUT_I,
	input  wire logic              WATCHDOG_ENABLE_I,
	input  wire logic              UNIMPL_OPCODE_I,
	input  wire logic              STOP_EXEC_I,
	input  wire logic              BACKGROUND_EXEC_I,
	input  wire logic              STOP_MODE_ENABLE_I,
	input  wire logic              BACKGROUND_MODE_ENABLE_I,
	input  wire logic              ILLEGAL_ADDRESS_I,
	input  wire logic              WAKEUP_RESET_I,
	input  wire rss_pkg::rss_mode_t POWER_MODE_I,
	output logic                   WATCHDOG_RESTART_O,
	output logic                   WAKEUP_SOURCE_FLAG_O,
	output logic                   MCU_RESET_O
);
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
		addr_hit = (addr == target);
	endfunction

	rss_cause_if cif ();

	logic pin_meta;
	logic pin_sync;
	logic trip_meta;
	logic trip_sync;
	logic low_voltage_reset;
	logic watchdog_reset;
	logic illegal_opcode;
	logic deep_stop;
	logic debug_force;
	logic cpu_status_wr;
	logic [7:0] status_view;

	// Pin and analog comparator levels come from outside the clock domain.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			pin_meta  <= 1'b1;
			pin_sync  <= 1'b1;
			trip_meta <= 1'b0;
			trip_sync <= 1'b0;
		end else begin
			pin_meta  <= RESET_PIN_N_I;
			pin_sync  <= pin_meta;
			trip_meta <= SUPPLY_BELOW_TRIP_I;
			trip_sync <= trip_meta;
		end
	end

	assign low_voltage_reset = trip_sync & LOW_VOLTAGE_RESET_ENABLE_I
		& LOW_VOLTAGE_STOP_DETECT_ENABLE_I; // see R11
	assign watchdog_reset = WATCHDOG_TIMEOUT_I & WATCHDOG_ENABLE_I; // see R7
	assign illegal_opcode = UNIMPL_OPCODE_I
		| (STOP_EXEC_I & ~STOP_MODE_ENABLE_I)
		| (BACKGROUND_EXEC_I & ~BACKGROUND_MODE_ENABLE_I); // see R8
	assign deep_stop = (POWER_MODE_I == rss_pkg::RSS_MODE_STOP2) || (POWER_MODE_I == rss_pkg::RSS_MODE_STOP1);
	// Only the debug port can reach the force bit; CPU writes there fall through.
	assign debug_force = DBG_WR_I && addr_hit(DBG_ADDR_I, FORCE_AD)
		&& DBG_WDATA_I[`RSS_BIT_FORCE]; // see R12 see R14 see R15
	assign cpu_status_wr = CPU_WR_I && addr_hit(CPU_ADDR_I, STATUS_AD);

	always_comb begin
		cif.cause = `RSS_ZERO_BYTE;
		if (low_voltage_reset) begin
			cif.cause = `RSS_FLAGS_POR; // see R4
		end
		cif.cause[`RSS_BIT_PIN]  = ~pin_sync; // see R6
		cif.cause[`RSS_BIT_WDOG] = watchdog_reset; // see R7
		cif.cause[`RSS_BIT_OPCODE]  = illegal_opcode; // see R8
		cif.cause[`RSS_BIT_BADADDR] = ILLEGAL_ADDRESS_I; // see R9
		cif.cause[`RSS_BIT_WAKE]    = WAKEUP_RESET_I & ~deep_stop; // see R10
	end

	// Resets with no status flag: debug force and wake-up out of the deepest stops.
	assign cif.quiet_reset = debug_force | (WAKEUP_RESET_I & deep_stop); // see R2 see R10

	rss_capture #(
		.HOLD_CYC (HOLD_CYC)
	) u_capture (
		.clk   (MCLK_I),
		.rst_n (RST_N_I),
		.cif   (cif)
	);

	assign MCU_RESET_O = cif.in_reset;
	assign status_view = cif.flags & `RSS_STATUS_MASK; // see R16

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			WATCHDOG_RESTART_O <= 1'b0;
		end else begin
			WATCHDOG_RESTART_O <= cpu_status_wr; // see R3
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			WAKEUP_SOURCE_FLAG_O <= 1'b0;
		end else begin
			WAKEUP_SOURCE_FLAG_O <= WAKEUP_RESET_I & deep_stop; // see R10
		end
	end

	// The force register has no read path, so it always returns zero.
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			CPU_RDATA_O <= `RSS_ZERO_BYTE;
		end else if (CPU_RD_I && addr_hit(CPU_ADDR_I, STATUS_AD)) begin
			CPU_RDATA_O <= status_view; // see R1
		end else begin
			CPU_RDATA_O <= `RSS_ZERO_BYTE; // see R13
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			DBG_RDATA_O <= `RSS_ZERO_BYTE;
		end else if (DBG_RD_I && addr_hit(DBG_ADDR_I, STATUS_AD)) begin
			DBG_RDATA_O <= status_view;
		end else begin
			DBG_RDATA_O <= `RSS_ZERO_BYTE; // see R13
		end
	end

	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	wdog_restart_a: assert property (cpu_status_wr |=> WATCHDOG_RESTART_O) // see R3
		else $error("status write did not restart the watchdog");
	flags_read_only_a: assert property (cpu_status_wr && cif.cause == '0 && !cif.quiet_reset
		|=> $stable(cif.flags)) // see R1
		else $error("CPU write changed the cause flags");
	force_reads_zero_a: assert property (DBG_RD_I && addr_hit(DBG_ADDR_I, FORCE_AD) |=> DBG_RDATA_O == '0) // see R13
		else $error("debug read of force register returned nonzero");
	cpu_force_zero_a: assert property (CPU_RD_I && addr_hit(CPU_ADDR_I, FORCE_AD) |=> CPU_RDATA_O == '0) // see R13
		else $error("CPU read of force register returned nonzero");
	status_bit0_a: assert property (CPU_RDATA_O[0] == 1'b0 && DBG_RDATA_O[0] == 1'b0) // see R16
		else $error("unimplemented status bit read as one");
	cpu_force_ignored_a: assert property (CPU_WR_I && addr_hit(CPU_ADDR_I, FORCE_AD) && !DBG_WR_I
		&& cif.cause == '0 && !cif.quiet_reset && !MCU_RESET_O |=> !MCU_RESET_O) // see R12
		else $error("CPU write to force register caused a reset");
	debug_force_reset_a: assert property (debug_force |=> MCU_RESET_O ##1 MCU_RESET_O) // see R14
		else $error("debug force did not reset the controller");
	watchdog_gate_a: assert property (!WATCHDOG_ENABLE_I |-> !cif.cause[`RSS_BIT_WDOG]) // see R7
		else $error("disabled watchdog produced a reset cause");
	low_voltage_gate_a: assert property (cif.cause[`RSS_BIT_LOWV] |-> LOW_VOLTAGE_RESET_ENABLE_I
		&& LOW_VOLTAGE_STOP_DETECT_ENABLE_I && trip_sync) // see R11
		else $error("low-voltage reset without both enables");
	pin_flag_a: assert property (!pin_sync && !MCU_RESET_O && !cif.cause[`RSS_BIT_POR]
		|=> cif.flags[`RSS_BIT_PIN]) // see R6
		else $error("pin reset not recorded in bit 6");
	deep_wakeup_a: assert property (WAKEUP_RESET_I && deep_stop |=> WAKEUP_SOURCE_FLAG_O
		&& !cif.flags[`RSS_BIT_WAKE]) // see R10
		else $error("deep stop wake-up flagged in the wrong place");
endmodule
